//--- hw/pdrs_regs.svh
// Purpose: offsets, field positions, reset values and timing counts of the sequencer
// Assumes: 125 MHz CLOCK, machine cycle of four clock states
// Notes:   included by the sequencer top only
`ifndef PDRS_REGS_SVH
`define PDRS_REGS_SVH

`define PDRS_OFS_POWER_CONTROL  8'h00
`define PDRS_OFS_AUX_CONFIG     8'h01
`define PDRS_OFS_WDOG_CONTROL   8'h02
`define PDRS_OFS_IRQ_CONTROL    8'h03
`define PDRS_OFS_STATUS         8'h04

`define PDRS_PWR_IDLE_BIT       0
`define PDRS_PWR_DOWN_BIT       1
`define PDRS_AUX_LPBSEL_BIT     4
`define PDRS_AUX_BODET_BIT      5
`define PDRS_IRQ_GLOBAL_BIT     0
`define PDRS_IRQ_EN_BIT0        1
`define PDRS_IRQ_LEVEL_BIT0     3

`define PDRS_WD_CLEAR_BIT       0
`define PDRS_WD_RST_EN_BIT      1
`define PDRS_WD_RST_FLAG_BIT    2
`define PDRS_WD_IRQ_FLAG_BIT    3
`define PDRS_WD_RUN_BIT         4
`define PDRS_WD_POR_FLAG_BIT    6

`define PDRS_WD_POR_VALUE       8'h40
`define PDRS_WD_EXT_KEEP        8'h56
`define PDRS_WD_WDT_KEEP        8'h52
`define PDRS_WD_WDT_SET         8'h04
`define PDRS_CTRL_RESET         8'h00
`define PDRS_PORT_RESET         8'hff
`define PDRS_PC_RESET           16'h0000
`define PDRS_SP_RESET           8'h07

`define PDRS_MC_STATES          2'd3
`define PDRS_HOLD_CYCLES        10'd8
`define PDRS_WDT_DELAY_CLOCKS   10'd512
`define PDRS_RST_SAMPLES        2'd2

`endif

//--- hw/pdrs_pkg.sv
// Purpose: types shared by the sequencer files
// Assumes: nothing
// Notes:   state codes are one-hot
package pdrs_pkg;
    typedef logic [7:0] pdrs_byte_type;
    typedef enum logic [3:0] {
        ST_RUN    = 4'b0001,
        ST_PD_ARM = 4'b0010,
        ST_PD     = 4'b0100,
        ST_RESET  = 4'b1000
    } pdrs_state_type;
endpackage

//--- hw/pdrs_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to CLOCK
// Notes:   first flop feeds only the second
module pdrs_sync #(
    parameter int          W    = 1,
    parameter logic [W-1:0] INIT = '1
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            meta_reg <= INIT;
            q        <= INIT;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule // pdrs_sync

//--- hw/pdrs_count.sv
// Purpose: loadable down counter with busy level and done pulse
// Assumes: load wins over counting
// Notes:   counts only while enable is high
module pdrs_count #(
    parameter int W = 10
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    input  wire logic         enable,
    output logic              busy,
    output logic              done
);
    logic [W-1:0] count_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            count_reg <= '0;
            done      <= 1'b0;
        end else if (load) begin
            count_reg <= value;
            done      <= 1'b0;
        end else if (enable && count_reg != '0) begin
            count_reg <= count_reg - W'(1);
            done      <= (count_reg == W'(1));
        end else begin
            done      <= 1'b0;
        end
    end

    assign busy = (count_reg != '0);
endmodule // pdrs_count

//--- hw/pdrs_top.sv
// Purpose: power-down control, reset sampling and stretching, reset source flags
// Assumes: CPU reports the last machine cycle of each instruction; watchdog
//          counter is outside and reports its time-out as a one-cycle pulse
// Notes:   pin inputs pass two flops; register reads answer one cycle later
//
// Implementation choices: the register offsets and the plain strobed port.
`include "pdrs_regs.svh"

module pdrs_top #(
    parameter logic [15:0] POR_DELAY_CYCLES = 16'd2048
) (
    input  wire logic                  CLOCK,
    input  wire logic                  SRST,
    input  wire pdrs_pkg::pdrs_byte_type ADDR,
    input  wire pdrs_pkg::pdrs_byte_type WDATA,
    input  wire logic                  WR,
    input  wire logic                  RD,
    output pdrs_pkg::pdrs_byte_type    RDATA,
    input  wire logic                  RST_N_PIN,
    input  wire logic [1:0]            INT_N_PIN,
    input  wire logic                  SUPPLY_OK,
    input  wire logic                  INSTR_LAST_CYCLE,
    input  wire logic                  WDT_TIMEOUT,
    input  wire logic                  CLK_SRC_EXTERNAL,
    output logic                       CORE_RESET,
    output logic [15:0]                PC_VALUE,
    output logic [7:0]                 SP_VALUE,
    output logic [7:0]                 PORT_INIT_VALUE,
    output logic                       CLOCKS_RUN,
    output logic                       PORT_HOLD,
    output logic                       RC_CLOCK_EN,
    output logic [1:0]                 WAKE_IRQ,
    output logic [1:0]                 PHASE,
    output logic                       WDT_RUN,
    output logic                       WDT_CLEAR,
    output logic                       WDT_COUNT_EN
);
    import pdrs_pkg::*;

    pdrs_state_type state_reg;
    pdrs_state_type state_next;
    logic [7:0]     power_control_reg;
    logic [7:0]     aux_config_reg;
    logic [7:0]     watchdog_control_reg;
    logic [7:0]     irq_control_reg;
    logic [1:0]     phase_reg;
    logic [1:0]     rst_low_cnt_reg;
    logic           ext_assert_d_reg;
    logic           rst_n_s;
    logic [1:0]     int_n_s;
    logic           supply_ok_s;
    logic           ext_assert;
    logic           ext_event;
    logic           por_busy;
    logic           por_active;
    logic           hold_busy;
    logic           hold_load;
    logic           wdt_delay_busy;
    logic           wdt_fire;
    logic           wdt_clear_cmd;
    logic           timeout_ok;
    logic           reset_active;
    logic           pd_done;
    logic [1:0]     wake_hit;
    logic           in_pd;

    // register address decode, used by every write path
    function automatic logic hit(input pdrs_byte_type a, input pdrs_byte_type ofs);
        hit = (a == ofs);
    endfunction

    pdrs_sync #(.W(4), .INIT(4'hf)) u_pin_sync (
        .clk  (CLOCK),
        .srst (SRST),
        .d    ({SUPPLY_OK, INT_N_PIN, RST_N_PIN}),
        .q    ({supply_ok_s, int_n_s, rst_n_s})
    );

    assign in_pd = (state_reg == ST_PD);

    // machine cycle states one to four; frozen while clocks are stopped
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            phase_reg <= 2'd0;
        end else if (!in_pd) begin
            phase_reg <= phase_reg + 2'd1;
        end
    end

    // reset pin sampled in state four, two low samples make a valid reset
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            rst_low_cnt_reg <= 2'd0;
        end else if (phase_reg == `PDRS_MC_STATES) begin
            if (rst_n_s) begin
                rst_low_cnt_reg <= 2'd0;
            end else if (rst_low_cnt_reg != `PDRS_RST_SAMPLES) begin
                rst_low_cnt_reg <= rst_low_cnt_reg + 2'd1;
            end
        end
    end

    // in power-down a low pin acts at once and restarts the clock
    assign ext_assert = !rst_n_s && (rst_low_cnt_reg == `PDRS_RST_SAMPLES || in_pd);
    assign ext_event  = ext_assert && !ext_assert_d_reg;

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            ext_assert_d_reg <= 1'b0;
        end else begin
            ext_assert_d_reg <= ext_assert;
        end
    end

    // power-on delay restarts whenever the supply dips
    pdrs_count #(.W(16)) u_por (
        .clk    (CLOCK),
        .srst   (SRST),
        .load   (!supply_ok_s),
        .value  (POR_DELAY_CYCLES),
        .enable (1'b1),
        .busy   (por_busy),
        .done   ()
    );
    assign por_active = !supply_ok_s || por_busy;

    // watchdog: no counting in power-down on an external clock source
    assign timeout_ok    = WDT_TIMEOUT && !(in_pd && CLK_SRC_EXTERNAL);
    assign wdt_clear_cmd = WR && hit(ADDR, `PDRS_OFS_WDOG_CONTROL) && WDATA[`PDRS_WD_CLEAR_BIT];

    pdrs_count #(.W(10)) u_wdt_delay (
        .clk    (CLOCK),
        .srst   (SRST),
        .load   (wdt_clear_cmd || reset_active ||
                 (timeout_ok && watchdog_control_reg[`PDRS_WD_RST_EN_BIT])),
        .value  ((wdt_clear_cmd || reset_active) ? 10'd0 : `PDRS_WDT_DELAY_CLOCKS),
        .enable (!(in_pd && CLK_SRC_EXTERNAL)),
        .busy   (wdt_delay_busy),
        .done   (wdt_fire)
    );

    // stretch: reloaded while a valid pin reset is asserted or on a watchdog reset
    assign hold_load = ext_assert || wdt_fire;

    pdrs_count #(.W(10)) u_hold (
        .clk    (CLOCK),
        .srst   (SRST),
        .load   (hold_load),
        .value  (`PDRS_HOLD_CYCLES),
        .enable (1'b1),
        .busy   (hold_busy),
        .done   ()
    );

    assign reset_active = por_active || hold_load || hold_busy;

    // wake: enabled, globally enabled, level mode, pin low
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_wake
            assign wake_hit[gi] = !int_n_s[gi]
                && irq_control_reg[`PDRS_IRQ_EN_BIT0 + gi]
                && irq_control_reg[`PDRS_IRQ_LEVEL_BIT0 + gi]
                && irq_control_reg[`PDRS_IRQ_GLOBAL_BIT];
        end
    endgenerate

    assign pd_done = (phase_reg == `PDRS_MC_STATES) && INSTR_LAST_CYCLE;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_RUN: begin
                if (power_control_reg[`PDRS_PWR_DOWN_BIT]) begin
                    state_next = ST_PD_ARM;
                end
            end
            ST_PD_ARM: begin
                if (pd_done) begin
                    state_next = ST_PD;
                end
            end
            ST_PD: begin
                if (wake_hit != 2'b00) begin
                    state_next = ST_RUN;
                end
            end
            ST_RESET: begin
                state_next = ST_RUN;
            end
        endcase
        if (reset_active) begin
            state_next = ST_RESET;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            state_reg <= ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // control registers cleared by any reset
    always_ff @(posedge CLOCK) begin
        if (SRST || reset_active) begin
            power_control_reg <= `PDRS_CTRL_RESET;
            aux_config_reg    <= `PDRS_CTRL_RESET;
            irq_control_reg   <= `PDRS_CTRL_RESET;
        end else begin
            if (WR && hit(ADDR, `PDRS_OFS_POWER_CONTROL)) begin
                power_control_reg <= WDATA;
            end else if (in_pd && wake_hit != 2'b00) begin
                power_control_reg[`PDRS_PWR_DOWN_BIT] <= 1'b0;
            end
            if (WR && hit(ADDR, `PDRS_OFS_AUX_CONFIG)) begin
                aux_config_reg <= WDATA;
            end
            if (WR && hit(ADDR, `PDRS_OFS_IRQ_CONTROL)) begin
                irq_control_reg <= WDATA;
            end
        end
    end

    // watchdog control: source-dependent reset values, set wins over write
    always_ff @(posedge CLOCK) begin
        if (SRST || por_active) begin
            watchdog_control_reg <= `PDRS_WD_POR_VALUE;
        end else if (wdt_fire) begin
            watchdog_control_reg <= (watchdog_control_reg & `PDRS_WD_WDT_KEEP)
                                    | `PDRS_WD_WDT_SET;
        end else if (ext_event) begin
            watchdog_control_reg <= watchdog_control_reg & `PDRS_WD_EXT_KEEP;
        end else begin
            if (WR && hit(ADDR, `PDRS_OFS_WDOG_CONTROL)) begin
                watchdog_control_reg <= {WDATA[7:1], 1'b0};
            end
            if (timeout_ok) begin
                watchdog_control_reg[`PDRS_WD_IRQ_FLAG_BIT] <= 1'b1;
            end
        end
    end

    // read data stand one cycle after the strobe
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            unique case (ADDR)
                `PDRS_OFS_POWER_CONTROL: RDATA <= power_control_reg;
                `PDRS_OFS_AUX_CONFIG:    RDATA <= aux_config_reg;
                `PDRS_OFS_WDOG_CONTROL:  RDATA <= watchdog_control_reg;
                `PDRS_OFS_IRQ_CONTROL:   RDATA <= irq_control_reg;
                `PDRS_OFS_STATUS:        RDATA <= {wdt_delay_busy, reset_active, phase_reg,
                                                   state_reg};
                default:                 RDATA <= 8'h00;
            endcase
        end else begin
            RDATA <= 8'h00;
        end
    end

    // core-facing outputs, all from flops
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            CORE_RESET      <= 1'b1;
            PC_VALUE        <= `PDRS_PC_RESET;
            SP_VALUE        <= `PDRS_SP_RESET;
            PORT_INIT_VALUE <= `PDRS_PORT_RESET;
            CLOCKS_RUN      <= 1'b1;
            PORT_HOLD       <= 1'b0;
            RC_CLOCK_EN     <= 1'b0;
            WAKE_IRQ        <= 2'b00;
            PHASE           <= 2'd0;
            WDT_RUN         <= 1'b0;
            WDT_CLEAR       <= 1'b0;
            WDT_COUNT_EN    <= 1'b0;
        end else begin
            CORE_RESET      <= reset_active;
            PC_VALUE        <= `PDRS_PC_RESET;
            SP_VALUE        <= `PDRS_SP_RESET;
            PORT_INIT_VALUE <= `PDRS_PORT_RESET;
            CLOCKS_RUN      <= (state_next != ST_PD);
            PORT_HOLD       <= (state_next == ST_PD);
            RC_CLOCK_EN     <= (state_next == ST_PD)
                               && aux_config_reg[`PDRS_AUX_LPBSEL_BIT]
                               && !aux_config_reg[`PDRS_AUX_BODET_BIT];
            WAKE_IRQ        <= (in_pd && !reset_active) ? wake_hit : 2'b00;
            PHASE           <= phase_reg;
            WDT_RUN         <= watchdog_control_reg[`PDRS_WD_RUN_BIT];
            WDT_CLEAR       <= wdt_clear_cmd;
            WDT_COUNT_EN    <= watchdog_control_reg[`PDRS_WD_RUN_BIT]
                               && !(state_next == ST_PD && CLK_SRC_EXTERNAL);
        end
    end
endmodule // pdrs_top

//--- verif/pdrs_asserts.sv
// Purpose: port-level timing checks of the sequencer
// Assumes: one clock, SRST synchronous and active high
// Notes:   bound into every pdrs_top
module pdrs_asserts (
    input wire logic                    CLOCK,
    input wire logic                    SRST,
    input wire pdrs_pkg::pdrs_byte_type ADDR,
    input wire pdrs_pkg::pdrs_byte_type WDATA,
    input wire logic                    WR,
    input wire logic                    RST_N_PIN,
    input wire logic                    CLK_SRC_EXTERNAL,
    input wire logic                    CORE_RESET,
    input wire logic [15:0]             PC_VALUE,
    input wire logic [7:0]              SP_VALUE,
    input wire logic [7:0]              PORT_INIT_VALUE,
    input wire logic                    CLOCKS_RUN,
    input wire logic                    PORT_HOLD,
    input wire logic                    RC_CLOCK_EN,
    input wire logic [1:0]              WAKE_IRQ,
    input wire logic                    WDT_CLEAR,
    input wire logic                    WDT_COUNT_EN
);
    import pdrs_pkg::*;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SRST);
    a_reset_consts: assert property (PC_VALUE == 16'h0000 && SP_VALUE == 8'h07
        && PORT_INIT_VALUE == 8'hff) else $error("reset constants wrong");
    a_hold_stops: assert property (PORT_HOLD |-> !CLOCKS_RUN)
        else $error("clocks run while ports held");
    a_rc_only_pd: assert property (RC_CLOCK_EN |-> PORT_HOLD)
        else $error("rc clock outside power-down");
    a_wdt_frozen: assert property (PORT_HOLD && $past(PORT_HOLD) && $past(CLK_SRC_EXTERNAL)
        |-> !WDT_COUNT_EN) else $error("watchdog counts in power-down");
    a_clear_pulse: assert property (WR && ADDR == 8'h02 && WDATA[0] && !CORE_RESET
        |-> ##[1:2] WDT_CLEAR) else $error("watchdog clear missing");
    a_wake_single: assert property (WAKE_IRQ != 2'h0 |=> WAKE_IRQ == 2'h0)
        else $error("wake pulse too long");
    a_reset_clocks: assert property (CORE_RESET [*2] |-> CLOCKS_RUN)
        else $error("clock stopped in reset");
    a_pin_reset: assert property ((!RST_N_PIN) [*8] ##1 (!RST_N_PIN) [*8] |-> CORE_RESET)
        else $error("long reset pin low ignored");
    a_reset_stretch: assert property ($rose(CORE_RESET) |=> CORE_RESET [*7])
        else $error("reset shorter than two machine cycles");
    a_release_late: assert property ($fell(CORE_RESET) |-> $past(RST_N_PIN, 9))
        else $error("reset left too soon after pin release");
    cover property (PORT_HOLD);
    cover property (WAKE_IRQ == 2'h1);
    cover property ($rose(CORE_RESET));
endmodule // pdrs_asserts

bind pdrs_top pdrs_asserts u_chk (.*);

//--- verif/pdrs_pins.sv
// Purpose: reset pin, interrupt pins and supply monitor outside the block
// Assumes: pins have pull-ups, idle high
// Notes:   driven after a rising edge
module pdrs_pins (
    input wire logic  CLOCK,
    output logic      RST_N_PIN,
    output logic [1:0] INT_N_PIN,
    output logic      SUPPLY_OK
);
    initial begin
        RST_N_PIN = 1'h1;
        INT_N_PIN = 2'h3;
        SUPPLY_OK = 1'h1;
    end
    // pin low for n clocks, at least nine for a sure valid reset
    task automatic reset_low(input int n);
        @(posedge CLOCK);
        RST_N_PIN <= 1'h0;
        repeat (n) @(posedge CLOCK);
        RST_N_PIN <= 1'h1;
    endtask
    // level request: pin driven to lvl and left there until the next call
    task automatic irq(input int pin, input logic lvl);
        @(posedge CLOCK);
        INT_N_PIN[pin] <= lvl;
    endtask
    task automatic supply(input logic ok);
        @(posedge CLOCK);
        SUPPLY_OK <= ok;
    endtask
endmodule // pdrs_pins

//--- verif/power_down_reset_sequencer_test.sv
// Purpose: self-checking bench of the sequencer
// Assumes: short power-on delay of 8
// Notes:   pins come from pdrs_pins
module power_down_reset_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    import pdrs_pkg::*;
    logic          CLOCK = 1'h0;
    logic          SRST = 1'h1;
    pdrs_byte_type ADDR = 8'h00;
    pdrs_byte_type WDATA = 8'h00;
    logic          WR = 1'h0;
    logic          RD = 1'h0;
    logic          INSTR_LAST_CYCLE = 1'h0;
    logic          WDT_TIMEOUT = 1'h0;
    logic          CLK_SRC_EXTERNAL = 1'h1;
    pdrs_byte_type RDATA;
    logic          RST_N_PIN, SUPPLY_OK, CORE_RESET, CLOCKS_RUN, PORT_HOLD, RC_CLOCK_EN;
    logic          WDT_RUN, WDT_CLEAR, WDT_COUNT_EN;
    logic [1:0]    INT_N_PIN, WAKE_IRQ, PHASE;
    logic [15:0]   PC_VALUE;
    logic [7:0]    SP_VALUE, PORT_INIT_VALUE;
    int            fails = 0;
    int            tests_run = 0;
    pdrs_byte_type d;
    always #4 CLOCK = ~CLOCK;
    pdrs_top #(.POR_DELAY_CYCLES(16'h0008)) dut (.*);
    pdrs_pins pins (.*);
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        if (fails == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wr(input pdrs_byte_type a, input pdrs_byte_type v);
        @(posedge CLOCK);
        ADDR <= a;
        WDATA <= v;
        WR <= 1'h1;
        @(posedge CLOCK);
        WR <= 1'h0;
    endtask
    task automatic rd(input pdrs_byte_type a);
        @(posedge CLOCK);
        ADDR <= a;
        RD <= 1'h1;
        @(posedge CLOCK);
        RD <= 1'h0;
        @(negedge CLOCK);
        d = RDATA;
    endtask
    task automatic wait_reset(input logic want);
        for (int n = 0; n < 200 && CORE_RESET !== want; n++) @(negedge CLOCK);
        check(CORE_RESET, want);
    endtask
    task automatic timeout_pulse;
        @(posedge CLOCK);
        WDT_TIMEOUT <= 1'h1;
        @(posedge CLOCK);
        WDT_TIMEOUT <= 1'h0;
    endtask
    task automatic enter_pd;
        wr(8'h00, 8'h02);
        @(posedge CLOCK);
        INSTR_LAST_CYCLE <= 1'h1;
        for (int n = 0; n < 20 && CLOCKS_RUN !== 1'h0; n++) @(negedge CLOCK);
        @(posedge CLOCK);
        INSTR_LAST_CYCLE <= 1'h0;
        check(CLOCKS_RUN, 1'h0);
        check(PORT_HOLD, 1'h1);
    endtask
    task automatic por_values;
        rd(8'h02);
        check(d, 8'h40);
        check(WDT_RUN, 1'h0);
        rd(8'h00);
        check(d, 8'h00);
        rd(8'h03);
        check(d, 8'h00);
        rd(8'h10);
        check(d, 8'h00);
        wr(8'h02, 8'h12);
        rd(8'h02);
        check(d, 8'h12);
    endtask
    task automatic ext_reset;
        pins.reset_low(2);
        repeat (20) @(posedge CLOCK);
        check(CORE_RESET, 1'h0);
        pins.reset_low(16);
        check(CORE_RESET, 1'h1);
        wait_reset(1'h0);
        rd(8'h02);
        check(d, 8'h12);
        check(WDT_RUN, 1'h1);
    endtask
    task automatic wdt_reset;
        int n;
        timeout_pulse;
        rd(8'h02);
        check(d, 8'h1a);
        wr(8'h02, 8'h1b);
        repeat (600) @(posedge CLOCK);
        check(CORE_RESET, 1'h0);
        timeout_pulse;
        for (n = 0; n < 600 && CORE_RESET !== 1'h1; n++) @(posedge CLOCK);
        check(n >= 512 && n <= 516, 1'h1);
        wait_reset(1'h0);
        rd(8'h02);
        check(d, 8'h16);
    endtask
    task automatic pd_wake;
        wr(8'h01, 8'h10);
        wr(8'h03, 8'h0b);
        wr(8'h00, 8'h02);
        repeat (20) @(posedge CLOCK);
        check(CLOCKS_RUN, 1'h1);
        enter_pd;
        check(RC_CLOCK_EN, 1'h1);
        check(WDT_COUNT_EN, 1'h0);
        pins.irq(1, 1'h0);
        repeat (20) @(posedge CLOCK);
        check(CLOCKS_RUN, 1'h0);
        pins.irq(0, 1'h0);
        for (int n = 0; n < 20 && WAKE_IRQ === 2'h0; n++) @(negedge CLOCK);
        check(WAKE_IRQ, 2'h1);
        pins.irq(0, 1'h1);
        pins.irq(1, 1'h1);
        rd(8'h00);
        check(d, 8'h00);
        check(CORE_RESET, 1'h0);
        check(CLOCKS_RUN, 1'h1);
    endtask
    task automatic pd_reset_exit;
        wr(8'h01, 8'h30);
        @(posedge CLOCK);
        CLK_SRC_EXTERNAL <= 1'h0;
        enter_pd;
        check(RC_CLOCK_EN, 1'h0);
        check(WDT_COUNT_EN, 1'h1);
        pins.reset_low(16);
        check(CORE_RESET, 1'h1);
        wait_reset(1'h0);
        check(CLOCKS_RUN, 1'h1);
        rd(8'h00);
        check(d, 8'h00);
        rd(8'h01);
        check(d, 8'h00);
        CLK_SRC_EXTERNAL <= 1'h1;
    endtask
    task automatic supply_loss;
        pins.supply(1'h0);
        repeat (10) @(posedge CLOCK);
        check(CORE_RESET, 1'h1);
        pins.supply(1'h1);
        wait_reset(1'h0);
        rd(8'h02);
        check(d, 8'h40);
        check(WDT_RUN, 1'h0);
    endtask
    initial begin
        #100000;
        fails++;
        complete_run;
    end
    initial begin
        repeat (10) @(posedge CLOCK);
        SRST <= 1'h0;
        wait_reset(1'h0);
        por_values;
        ext_reset;
        wdt_reset;
        pd_wake;
        pd_reset_exit;
        supply_loss;
        complete_run;
    end
endmodule // power_down_reset_sequencer_test
